/* File: hdl/bmwr_pkg.sv */
// Package with offsets, field layouts and reset values of the bridge memory window registers.
package bmwr_pkg;

    // ==========================================================
    // Bus and window geometry
    // ==========================================================
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FIELD_W = 12;
    localparam int LOW_W = 20;
    localparam int NUM_WIN = 2;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [ADDR_W-1:0] OFF_MEM_WIN = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_PREF_WIN = 12'h024;
    localparam logic [ADDR_W-1:0] OFF_PREF_BASE_HI = 12'h028;
    localparam logic [ADDR_W-1:0] OFF_PREF_LIMIT_HI = 12'h02C;
    localparam logic [ADDR_W-1:0] OFF_FWD_STATUS = 12'h040;

    // ==========================================================
    // Field positions inside a register word
    // ==========================================================
    localparam int BASE_LSB = 4;
    localparam int LIMIT_LSB = 20;
    localparam int IND_BASE_LSB = 0;
    localparam int IND_LIMIT_LSB = 16;
    localparam int STAT_CROSS_BIT = 0;
    localparam int STAT_MEM_HIT_BIT = 1;
    localparam int STAT_PREF_HIT_BIT = 2;
    localparam int STAT_COUNT_LSB = 16;

    // ==========================================================
    // Fixed values and reset values
    // ==========================================================
    localparam logic [3:0] IND_64BIT = 4'h1;
    localparam logic [LOW_W-1:0] LOW_ONES = 20'hFFFFF;
    localparam logic [LOW_W-1:0] LOW_ZERO = 20'h00000;
    localparam logic [FIELD_W-1:0] FIELD_RST = 12'h000;
    localparam logic [31:0] UPPER_RST = 32'h00000000;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    // ==========================================================
    // Bus slave states
    // ==========================================================
    typedef enum logic [0:0] {
        BMWR_ST_IDLE = 1'b0,
        BMWR_ST_ACCESS = 1'b1
    } bmwr_apb_state_t;

endpackage

/* File: hdl/bmwr_window_match.sv */
// Comparator that tells whether a 64-bit address falls inside one window.
`timescale 1ns/1ps

module bmwr_window_match
    import bmwr_pkg::*;
(
    // Address under test.
    input wire logic [63:0] i_addr,
    // Window bounds, both inclusive.
    input wire logic [63:0] i_base,
    input wire logic [63:0] i_limit,
    // Match result.
    output logic o_hit
);

    logic win_open;

    // ==========================================================
    // Inclusive range compare
    // ==========================================================
    always_comb begin
        // A base above the limit closes the window; cleared reset values still leave the first megabyte open.
        win_open = (i_base <= i_limit); // RULE11
        o_hit = win_open && (i_addr >= i_base) && (i_addr <= i_limit); // RULE11
    end

endmodule

/* File: hdl/bmwr_regs.sv */
// Memory window registers of a bridge port and the forwarding decision built on them.
//
// Overview of operation
// RULE1: memory limit low twenty bits read as ones
// RULE2: memory window decides cross-interface forwarding
// RULE3: both 64-bit indicator nibbles always read 1h
// RULE4: prefetch base bits 15:4 give address 31:20
// RULE5: prefetch limit bits 31:20, low bits ones
// RULE6: upper base register gives address bits 63:32
// RULE7: upper limit comes from its own register
// RULE8: all writable window fields clear at reset
// RULE9: prefetch window decides memory read/write forwarding
// RULE10: memory base bits 15:4, low bits zero
// RULE11: inclusive compare, base above limit disables window
`timescale 1ns/1ps

module bmwr_regs
    import bmwr_pkg::*;
(
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // APB slave port.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pslverr,
    // Transaction to be routed.
    input wire logic i_req_valid,
    input wire logic i_req_is_mem,
    input wire logic i_req_from_primary,
    input wire logic [63:0] i_req_addr,
    // Routing decision.
    output logic o_fwd_valid,
    output logic o_fwd_cross,
    output logic o_fwd_mem_hit,
    output logic o_fwd_pref_hit
);

    // ==========================================================
    // Declarations
    // ==========================================================
    bmwr_apb_state_t state_reg;
    bmwr_apb_state_t state_next;
    logic pready_reg;
    logic pready_next;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic pslverr_reg;
    logic pslverr_next;

    logic [FIELD_W-1:0] mem_base_reg;
    logic [FIELD_W-1:0] mem_base_next;
    logic [FIELD_W-1:0] mem_limit_reg;
    logic [FIELD_W-1:0] mem_limit_next;
    logic [FIELD_W-1:0] pref_base_reg;
    logic [FIELD_W-1:0] pref_base_next;
    logic [FIELD_W-1:0] pref_limit_reg;
    logic [FIELD_W-1:0] pref_limit_next;
    logic [31:0] pref_base_hi_reg;
    logic [31:0] pref_base_hi_next;
    logic [31:0] pref_limit_hi_reg;
    logic [31:0] pref_limit_hi_next;

    logic fwd_valid_reg;
    logic fwd_valid_next;
    logic fwd_cross_reg;
    logic fwd_cross_next;
    logic fwd_mem_hit_reg;
    logic fwd_mem_hit_next;
    logic fwd_pref_hit_reg;
    logic fwd_pref_hit_next;
    logic [15:0] fwd_count_reg;
    logic [15:0] fwd_count_next;

    logic setup_phase;
    logic wr_fire;
    logic addr_mapped;
    logic [DATA_W-1:0] mem_word;
    logic [DATA_W-1:0] pref_word;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] wr_word;

    logic [63:0] mem_base_addr;
    logic [63:0] mem_limit_addr;
    logic [63:0] pref_base_addr;
    logic [63:0] pref_limit_addr;
    logic [63:0] win_base [NUM_WIN];
    logic [63:0] win_limit [NUM_WIN];
    logic [NUM_WIN-1:0] win_hit;
    logic any_hit;

    // Byte-lane merge so that a partial write keeps the lanes it does not strobe.
    function automatic logic [DATA_W-1:0] merge_lanes(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [3:0] strb
    );
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // Register words as software sees them
    // ==========================================================
    always_comb begin
        mem_word = '0;
        mem_word[BASE_LSB +: FIELD_W] = mem_base_reg;
        mem_word[LIMIT_LSB +: FIELD_W] = mem_limit_reg;
        pref_word = '0;
        pref_word[IND_BASE_LSB +: 4] = IND_64BIT; // RULE3
        pref_word[IND_LIMIT_LSB +: 4] = IND_64BIT; // RULE3
        pref_word[BASE_LSB +: FIELD_W] = pref_base_reg;
        pref_word[LIMIT_LSB +: FIELD_W] = pref_limit_reg;
        status_word = '0;
        status_word[STAT_CROSS_BIT] = fwd_cross_reg;
        status_word[STAT_MEM_HIT_BIT] = fwd_mem_hit_reg;
        status_word[STAT_PREF_HIT_BIT] = fwd_pref_hit_reg;
        status_word[STAT_COUNT_LSB +: 16] = fwd_count_reg;
    end

    // ==========================================================
    // APB slave: one wait-free access phase after each setup
    // ==========================================================
    always_comb begin
        setup_phase = i_psel && !i_penable;
        wr_fire = i_psel && i_penable && pready_reg && i_pwrite;
        addr_mapped = 1'b1;
        rd_word = '0;
        case (i_paddr)
            OFF_MEM_WIN: rd_word = mem_word;
            OFF_PREF_WIN: rd_word = pref_word;
            OFF_PREF_BASE_HI: rd_word = pref_base_hi_reg;
            OFF_PREF_LIMIT_HI: rd_word = pref_limit_hi_reg;
            OFF_FWD_STATUS: rd_word = status_word;
            default: addr_mapped = 1'b0;
        endcase
        state_next = state_reg;
        pready_next = 1'b0;
        prdata_next = '0;
        pslverr_next = 1'b0;
        case (state_reg)
            BMWR_ST_IDLE: begin
                if (setup_phase) begin
                    state_next = BMWR_ST_ACCESS;
                    pready_next = 1'b1;
                    pslverr_next = !addr_mapped;
                    prdata_next = i_pwrite ? '0 : rd_word;
                end
            end
            BMWR_ST_ACCESS: begin
                state_next = BMWR_ST_IDLE;
            end
            default: begin
                state_next = BMWR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_reg <= BMWR_ST_IDLE;
            pready_reg <= 1'b0;
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pready_reg <= pready_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ==========================================================
    // Window registers
    // ==========================================================
    always_comb begin
        mem_base_next = mem_base_reg;
        mem_limit_next = mem_limit_reg;
        pref_base_next = pref_base_reg;
        pref_limit_next = pref_limit_reg;
        pref_base_hi_next = pref_base_hi_reg;
        pref_limit_hi_next = pref_limit_hi_reg;
        wr_word = '0;
        if (wr_fire) begin
            case (i_paddr)
                OFF_MEM_WIN: begin
                    wr_word = merge_lanes(mem_word, i_pwdata, i_pstrb);
                    mem_base_next = wr_word[BASE_LSB +: FIELD_W]; // RULE10
                    mem_limit_next = wr_word[LIMIT_LSB +: FIELD_W]; // RULE1
                end
                OFF_PREF_WIN: begin
                    wr_word = merge_lanes(pref_word, i_pwdata, i_pstrb);
                    pref_base_next = wr_word[BASE_LSB +: FIELD_W]; // RULE4
                    pref_limit_next = wr_word[LIMIT_LSB +: FIELD_W]; // RULE5
                end
                OFF_PREF_BASE_HI: begin
                    pref_base_hi_next = merge_lanes(pref_base_hi_reg, i_pwdata, i_pstrb); // RULE6
                end
                OFF_PREF_LIMIT_HI: begin
                    pref_limit_hi_next = merge_lanes(pref_limit_hi_reg, i_pwdata, i_pstrb); // RULE7
                end
                default: begin
                    wr_word = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mem_base_reg <= FIELD_RST; // RULE8
            mem_limit_reg <= FIELD_RST; // RULE8
            pref_base_reg <= FIELD_RST; // RULE8
            pref_limit_reg <= FIELD_RST; // RULE8
            pref_base_hi_reg <= UPPER_RST; // RULE8
            pref_limit_hi_reg <= UPPER_RST;
        end else begin
            mem_base_reg <= mem_base_next;
            mem_limit_reg <= mem_limit_next;
            pref_base_reg <= pref_base_next;
            pref_limit_reg <= pref_limit_next;
            pref_base_hi_reg <= pref_base_hi_next;
            pref_limit_hi_reg <= pref_limit_hi_next;
        end
    end

    // ==========================================================
    // Window bounds and address compare
    // ==========================================================
    always_comb begin
        // The plain memory window only covers the low 4 GB.
        mem_base_addr = {32'h00000000, mem_base_reg, LOW_ZERO}; // RULE10
        mem_limit_addr = {32'h00000000, mem_limit_reg, LOW_ONES}; // RULE1
        pref_base_addr = {pref_base_hi_reg, pref_base_reg, LOW_ZERO}; // RULE4 RULE6
        pref_limit_addr = {pref_limit_hi_reg, pref_limit_reg, LOW_ONES}; // RULE5 RULE7
        win_base[0] = mem_base_addr;
        win_limit[0] = mem_limit_addr;
        win_base[1] = pref_base_addr;
        win_limit[1] = pref_limit_addr;
    end

    for (genvar g = 0; g < NUM_WIN; g++) begin : g_win
        bmwr_window_match u_match (
            .i_addr(i_req_addr),
            .i_base(win_base[g]),
            .i_limit(win_limit[g]),
            .o_hit(win_hit[g])
        );
    end

    // ==========================================================
    // Forwarding decision
    // ==========================================================
    always_comb begin
        any_hit = |win_hit;
        fwd_valid_next = i_req_valid;
        fwd_mem_hit_next = fwd_mem_hit_reg;
        fwd_pref_hit_next = fwd_pref_hit_reg;
        fwd_cross_next = 1'b0;
        fwd_count_next = fwd_count_reg;
        if (i_req_valid) begin
            fwd_mem_hit_next = i_req_is_mem && win_hit[0]; // RULE2
            fwd_pref_hit_next = i_req_is_mem && win_hit[1]; // RULE9
            // Downstream traffic crosses on a hit, upstream traffic crosses on a miss.
            if (i_req_is_mem) begin
                fwd_cross_next = i_req_from_primary ? any_hit : !any_hit; // RULE2 RULE9
            end
            if (fwd_cross_next) begin
                fwd_count_next = fwd_count_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            fwd_valid_reg <= 1'b0;
            fwd_cross_reg <= 1'b0;
            fwd_mem_hit_reg <= 1'b0;
            fwd_pref_hit_reg <= 1'b0;
            fwd_count_reg <= COUNT_RST;
        end else begin
            fwd_valid_reg <= fwd_valid_next;
            fwd_cross_reg <= fwd_cross_next;
            fwd_mem_hit_reg <= fwd_mem_hit_next;
            fwd_pref_hit_reg <= fwd_pref_hit_next;
            fwd_count_reg <= fwd_count_next;
        end
    end

    assign o_pready = pready_reg;
    assign o_prdata = prdata_reg;
    assign o_pslverr = pslverr_reg;
    assign o_fwd_valid = fwd_valid_reg;
    assign o_fwd_cross = fwd_cross_reg;
    assign o_fwd_mem_hit = fwd_mem_hit_reg;
    assign o_fwd_pref_hit = fwd_pref_hit_reg;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_setup;
        i_psel && !i_penable;
    endsequence

    sequence s_full_write(logic [ADDR_W-1:0] off);
        wr_fire && (i_paddr == off) && (i_pstrb == 4'hF);
    endsequence

    sequence s_pref_read;
        i_psel && !i_penable && !i_pwrite && (i_paddr == OFF_PREF_WIN);
    endsequence

    a_apb_ready_answer: assert property (s_setup |=> o_pready ##1 !o_pready)
        else $error("pready not a single cycle after setup");

    a_mem_limit_ones: assert property (s_full_write(OFF_MEM_WIN) |=> // RULE1
        (mem_limit_addr[31:20] == $past(i_pwdata[31:20])) && (mem_limit_addr[19:0] == LOW_ONES))
        else $error("memory window top address wrong after write");

    a_mem_base_zero: assert property (s_full_write(OFF_MEM_WIN) |=> // RULE10
        (mem_base_addr[31:20] == $past(i_pwdata[15:4])) && (mem_base_addr[19:0] == LOW_ZERO))
        else $error("memory window bottom address wrong after write");

    a_pref_indicator: assert property (s_pref_read |=> // RULE3
        (o_prdata[3:0] == IND_64BIT) && (o_prdata[19:16] == IND_64BIT))
        else $error("64-bit indicator nibbles not 1h");

    a_pref_base_low: assert property (s_full_write(OFF_PREF_WIN) |=> // RULE4
        (pref_base_addr[31:20] == $past(i_pwdata[15:4])) && (pref_base_addr[19:0] == LOW_ZERO))
        else $error("prefetch bottom address wrong after write");

    a_pref_limit_low: assert property (s_full_write(OFF_PREF_WIN) |=> // RULE5
        (pref_limit_addr[31:20] == $past(i_pwdata[31:20])) && (pref_limit_addr[19:0] == LOW_ONES))
        else $error("prefetch top address wrong after write");

    a_pref_base_upper: assert property (s_full_write(OFF_PREF_BASE_HI) |=> // RULE6
        pref_base_addr[63:32] == $past(i_pwdata))
        else $error("prefetch upper base not taken from write");

    a_pref_limit_upper: assert property (s_full_write(OFF_PREF_LIMIT_HI) |=> // RULE7
        (pref_limit_addr[63:32] == $past(i_pwdata)) && $stable(pref_limit_reg))
        else $error("prefetch upper limit not from its own register");

    a_reset_fields_zero: assert property ($past(i_rst) |-> // RULE8
        (mem_base_reg == FIELD_RST) && (mem_limit_reg == FIELD_RST) && (pref_base_reg == FIELD_RST)
        && (pref_limit_reg == FIELD_RST) && (pref_base_hi_reg == UPPER_RST))
        else $error("window fields not clear after reset");

    a_down_hit_crosses: assert property (i_req_valid && i_req_is_mem && i_req_from_primary // RULE9
        && (i_req_addr >= pref_base_addr) && (i_req_addr <= pref_limit_addr) |=> o_fwd_cross)
        else $error("downstream hit in prefetch window not forwarded");

    a_closed_window: assert property (i_req_valid && !i_req_from_primary // RULE11
        && (mem_base_addr > mem_limit_addr) && (pref_base_addr > pref_limit_addr)
        |=> o_fwd_valid && (o_fwd_cross == $past(i_req_is_mem)) && !o_fwd_mem_hit)
        else $error("closed windows must not claim upstream traffic");

endmodule

/* File: tb/bmwr_regs_tb.sv */
// Self-checking testbench for the bridge memory window registers and forwarding decision.
`timescale 1ns/1ps

module bridge_memory_window_regs_tb_top;
    import bmwr_pkg::*;

    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [ADDR_W-1:0] i_paddr = '0;
    logic [DATA_W-1:0] i_pwdata = '0;
    logic [3:0] i_pstrb = 4'h0;
    logic o_pready;
    logic [DATA_W-1:0] o_prdata;
    logic o_pslverr;
    logic i_req_valid = 1'b0;
    logic i_req_is_mem = 1'b0;
    logic i_req_from_primary = 1'b0;
    logic [63:0] i_req_addr = '0;
    logic o_fwd_valid;
    logic o_fwd_cross;
    logic o_fwd_mem_hit;
    logic o_fwd_pref_hit;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [15:0] cross_cnt = 16'h0000;
    logic [2:0] last_stat = 3'h0;

    always #20 i_sys_clk = ~i_sys_clk;

    bmwr_regs i_bmwr_regs (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
        .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
        .i_req_valid(i_req_valid), .i_req_is_mem(i_req_is_mem),
        .i_req_from_primary(i_req_from_primary), .i_req_addr(i_req_addr),
        .o_fwd_valid(o_fwd_valid), .o_fwd_cross(o_fwd_cross),
        .o_fwd_mem_hit(o_fwd_mem_hit), .o_fwd_pref_hit(o_fwd_pref_hit)
    );

    // ==========================================================
    // Reporting
    // ==========================================================
    task automatic complete_run();
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // The whole run needs well under a thousand cycles; the ceiling leaves ample margin.
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles > 5000) begin
            errors++;
            $display("unexpected at %0t: run did not finish in time", $time);
            complete_run();
        end
    end

    // ==========================================================
    // Bus and request drivers
    // ==========================================================
    // Entered just after a rising edge; the request is held until pready is seen high.
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [31:0] rd, output logic err);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        i_pstrb <= s;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        // Read data and error are taken at the very edge where pready is sampled high.
        // A missing answer is caught by the run timeout, not here.
        do begin
            @(posedge i_sys_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, a, d, s, rd, err);
        chk_bit(err, exp_err, "write error flag");
    endtask

    task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b0, a, 32'h00000000, 4'h0, rd, err);
        chk_word(rd, exp, "read data");
        chk_bit(err, exp_err, "read error flag");
    endtask

    // One request; the decision and hit flags are judged in the cycle after it, and the memory hit is checked as held one later.
    task automatic route(input logic prim, input logic mem, input logic [63:0] a,
                         input logic mh, input logic ph);
        logic cr;
        cr = mem & (prim ? (mh | ph) : !(mh | ph));
        i_req_valid <= 1'b1;
        i_req_is_mem <= mem;
        i_req_from_primary <= prim;
        i_req_addr <= a;
        @(posedge i_sys_clk);
        i_req_valid <= 1'b0;
        @(negedge i_sys_clk);
        chk_bit(o_fwd_valid, 1'b1, "forward valid");
        chk_bit(o_fwd_cross, cr, "forward cross");
        chk_bit(o_fwd_mem_hit, mh & mem, "memory hit");
        chk_bit(o_fwd_pref_hit, ph & mem, "prefetch hit");
        @(negedge i_sys_clk);
        chk_bit(o_fwd_valid, 1'b0, "forward valid pulse end");
        chk_bit(o_fwd_cross, 1'b0, "cross pulse end");
        chk_bit(o_fwd_mem_hit, mh & mem, "memory hit held");
        @(posedge i_sys_clk);
        if (cr) begin
            cross_cnt = cross_cnt + 16'h0001;
        end
        // The cross bit is a one-cycle pulse, so a later status read finds it low.
        last_stat = {ph & mem, mh & mem, 1'b0};
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic test_reset_values();
        rd_reg(OFF_MEM_WIN, 32'h00000000, 1'b0);
        rd_reg(OFF_PREF_WIN, {12'h000, IND_64BIT, 12'h000, IND_64BIT}, 1'b0);
        rd_reg(OFF_PREF_BASE_HI, UPPER_RST, 1'b0);
        rd_reg(OFF_PREF_LIMIT_HI, 32'h00000000, 1'b0);
        // Cleared fields still describe open windows over the first megabyte.
        route(1'b1, 1'b1, 64'h00000000000FFFFF, 1'b1, 1'b1);
        route(1'b0, 1'b1, 64'h0000000000100000, 1'b0, 1'b0);
    endtask

    task automatic test_field_access();
        wr_reg(OFF_MEM_WIN, 32'hFFFFFFFF, 4'hF, 1'b0);
        rd_reg(OFF_MEM_WIN, 32'hFFF0FFF0, 1'b0);
        wr_reg(OFF_PREF_WIN, 32'h00000000, 4'hF, 1'b0);
        rd_reg(OFF_PREF_WIN, {12'h000, IND_64BIT, 12'h000, IND_64BIT}, 1'b0);
        wr_reg(OFF_PREF_BASE_HI, 32'h00000001, 4'hF, 1'b0);
        wr_reg(OFF_PREF_BASE_HI, 32'hFFFFFFFF, 4'h2, 1'b0);
        rd_reg(OFF_PREF_BASE_HI, 32'h0000FF01, 1'b0);
        wr_reg(12'h030, 32'hFFFFFFFF, 4'hF, 1'b1);
        rd_reg(12'h030, 32'h00000000, 1'b1);
    endtask

    task automatic test_windows();
        wr_reg(OFF_MEM_WIN, 32'h00200010, 4'hF, 1'b0);
        wr_reg(OFF_PREF_WIN, 32'h00600050, 4'hF, 1'b0);
        wr_reg(OFF_PREF_BASE_HI, 32'h00000001, 4'hF, 1'b0);
        wr_reg(OFF_PREF_LIMIT_HI, 32'h00000001, 4'hF, 1'b0);
        rd_reg(OFF_PREF_WIN, {12'h006, IND_64BIT, 12'h005, IND_64BIT}, 1'b0);
        route(1'b1, 1'b1, 64'h00000000000FFFFF, 1'b0, 1'b0);
        route(1'b1, 1'b1, 64'h0000000000100000, 1'b1, 1'b0);
        route(1'b0, 1'b1, 64'h00000000002FFFFF, 1'b1, 1'b0);
        route(1'b0, 1'b1, 64'h0000000000300000, 1'b0, 1'b0);
        route(1'b1, 1'b1, 64'h0000000100100000, 1'b0, 1'b0);
        route(1'b1, 1'b1, 64'h0000000100500000, 1'b0, 1'b1);
        route(1'b1, 1'b1, 64'h0000000000500000, 1'b0, 1'b0);
        route(1'b0, 1'b1, 64'h00000001006FFFFF, 1'b0, 1'b1);
        route(1'b1, 1'b1, 64'h0000000100700000, 1'b0, 1'b0);
        route(1'b1, 1'b0, 64'h0000000000100000, 1'b0, 1'b0);
        wr_reg(OFF_PREF_LIMIT_HI, 32'h00000002, 4'hF, 1'b0);
        route(1'b1, 1'b1, 64'h0000000200000000, 1'b0, 1'b1);
        wr_reg(OFF_PREF_WIN, 32'h00600070, 4'hF, 1'b0);
        wr_reg(OFF_PREF_LIMIT_HI, 32'h00000001, 4'hF, 1'b0);
        route(1'b1, 1'b1, 64'h0000000100600000, 1'b0, 1'b0);
        wr_reg(OFF_MEM_WIN, 32'h00100020, 4'hF, 1'b0);
        route(1'b0, 1'b1, 64'h0000000000100000, 1'b0, 1'b0);
        wr_reg(OFF_MEM_WIN, 32'h00200010, 4'hF, 1'b0);
        route(1'b1, 1'b1, 64'h0000000000200000, 1'b1, 1'b0);
    endtask

    task automatic test_status();
        wr_reg(OFF_FWD_STATUS, 32'hFFFFFFFF, 4'hF, 1'b0);
        rd_reg(OFF_FWD_STATUS, {cross_cnt, 13'h0000, last_stat}, 1'b0);
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        test_reset_values();
        test_field_access();
        test_windows();
        test_status();
        complete_run();
    end
endmodule
